/* File: rtl/pmof_regs.svh */
// constants for the performance-monitor overflow and freeze block
`ifndef PMOF_REGS_SVH
`define PMOF_REGS_SVH

// register indices of the overflow status registers
`define PMOF_STAT0_IDX 8'h00
`define PMOF_STAT1_IDX 8'h01
`define PMOF_STAT3_IDX 8'h03
// generic counter pairs 4..7, counter width in bits
`define PMOF_FIRST_CTR 4
`define PMOF_LAST_CTR  7
`define PMOF_NUM_CTR   4
`define PMOF_CNT_W     32
// model-specific monitor reports at this status bit
`define PMOF_MS_BIT    8
// field positions
`define PMOF_FR_BIT    0
`define PMOF_PLM_LSB   0
`define PMOF_OI_BIT    5
`define PMOF_PM_BIT    6
`define PMOF_ES_LSB    8
// reset values
`define PMOF_FR_RST    1'b0
`define PMOF_OVF_RST   5'h00
`define PMOF_CNT_RST   32'h0000_0000

`endif

/* File: rtl/pmof_pkg.sv */
// types shared by the performance-monitor overflow and freeze block
`include "pmof_regs.svh"
package pmof_pkg;
    // per-counter configuration, only implemented fields kept
    typedef struct packed {
        logic       es_cycles;  // event select bit 0: 0 retired instr, 1 cycles
        logic       pm;
        logic       oi;
        logic [3:0] plm;
    } pmof_cfg_t;

    typedef struct packed {
        logic                                      fr;
        logic [`PMOF_MS_BIT:`PMOF_FIRST_CTR]       ovf;
        pmof_cfg_t [`PMOF_NUM_CTR-1:0]             cfg;
        logic [63:0]                               rdata;
        logic                                      rvalid;
        logic                                      irq;
    } pmof_top_state_t;

    typedef struct packed {
        logic [`PMOF_CNT_W-1:0] count;
    } pmof_ctr_state_t;
endpackage : pmof_pkg

/* File: rtl/pmof_cnt_if.sv */
// link between the monitor control and one generic counter
`timescale 1ns/1ps
`default_nettype none
`include "pmof_regs.svh"
interface pmof_cnt_if;
    logic                   inc;
    logic                   wr;
    logic [`PMOF_CNT_W-1:0] wdata;
    logic [`PMOF_CNT_W-1:0] count;
    logic                   ovf;
    modport ctr (input inc, input wr, input wdata, output count, output ovf);
    modport mon (output inc, output wr, output wdata, input count, input ovf);
endinterface : pmof_cnt_if
`default_nettype wire

/* File: rtl/pmof_counter.sv */
// one generic event counter with wrap detection
`timescale 1ns/1ps
`default_nettype none
`include "pmof_regs.svh"
module pmof_counter (
    // clock and reset
    input wire logic  mclk,
    input wire logic  rst_n,
    // control side
    pmof_cnt_if.ctr   bus
);
    pmof_pkg::pmof_ctr_state_t q, d;

    // a software load wins over a count in the same cycle
    always_comb begin
        d = q;
        if (bus.wr) begin
            d.count = bus.wdata;
        end else if (bus.inc) begin
            d.count = q.count + `PMOF_CNT_W'(1);  // only ever counts up
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q.count <= `PMOF_CNT_RST;
        end else begin
            q <= d;
        end
    end

    assign bus.count = q.count;
    // carry out of the top count bit
    assign bus.ovf   = bus.inc & ~bus.wr & (&q.count);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_wrap;
        (bus.inc && !bus.wr && (&q.count)) |=> (q.count == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
endmodule : pmof_counter
`default_nettype wire

/* File: rtl/pmof_top.sv */
// performance-monitor access gating, overflow status and freeze control
`timescale 1ns/1ps
`default_nettype none
`include "pmof_regs.svh"
module pmof_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // processor status fields
    input  wire logic [1:0]  current_priv_level,
    input  wire logic        user_monitor_enable,
    input  wire logic        priv_monitor_enable,
    input  wire logic        secure_monitor_flag,
    input  wire logic        overflow_vector_mask,
    // countable events and model-specific monitor
    input  wire logic        evt_retired_instr,
    input  wire logic        ms_irq_req,
    // move-to / move-from requests
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_is_data,
    input  wire logic [7:0]  req_index,
    input  wire logic [63:0] req_wdata,
    // answers and status
    output logic [63:0]      rsp_rdata,
    output logic             rsp_valid,
    output logic             freeze_bit,
    output logic             perf_irq_pend
);
    localparam int NC = `PMOF_NUM_CTR;
    localparam int W  = `PMOF_CNT_W;

    pmof_pkg::pmof_top_state_t q, d;

    logic [NC-1:0]          ctr_ovf;
    logic [NC-1:0]          ctr_inc;
    logic [NC-1:0]          ctr_oi;
    logic [W-1:0]           ctr_cnt [NC];
    logic                   in_ctr_range;
    logic                   data_wr;
    logic                   stat_wr0;
    logic                   ms_evt;
    logic                   irq_evt;
    logic [1:0]             sel;
    logic [63:0]            stat0_view;

    pmof_cnt_if cif [NC] ();

    assign in_ctr_range = (req_index >= 8'(`PMOF_FIRST_CTR)) &&
                          (req_index <= 8'(`PMOF_LAST_CTR));
    assign sel          = req_index[1:0];  // indices 4..7 map to slots 0..3
    assign data_wr      = req_valid & req_write & req_is_data & in_ctr_range;
    assign stat_wr0     = req_valid & req_write & ~req_is_data &
                          (req_index == `PMOF_STAT0_IDX);

    // per-counter enable and event selection
    for (genvar g = 0; g < NC; g++) begin : g_ctr
        logic en;
        assign en = ~q.fr & q.cfg[g].plm[current_priv_level] &
                    (q.cfg[g].pm ? priv_monitor_enable : user_monitor_enable);
        assign ctr_inc[g]   = en & (q.cfg[g].es_cycles | evt_retired_instr);
        assign cif[g].inc   = ctr_inc[g];
        assign cif[g].wr    = data_wr && (sel == 2'(g));
        assign cif[g].wdata = req_wdata[W-1:0];
        assign ctr_cnt[g]   = cif[g].count;
        assign ctr_ovf[g]   = cif[g].ovf;
        assign ctr_oi[g]    = q.cfg[g].oi;
        pmof_counter u_ctr (
            .mclk  (mclk),
            .rst_n (rst_n),
            .bus   (cif[g])
        );
    end

    // model-specific requests are frozen along with the counters
    assign ms_evt  = ms_irq_req & ~q.fr;
    assign irq_evt = (|(ctr_ovf & ctr_oi)) | ms_evt;

    // status register 0 as software sees it; bits 3:1 read zero
    assign stat0_view = {55'h0, q.ovf, 3'h0, q.fr};

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        d.irq    = 1'b0;
        // software writes: clears and loads come first
        if (req_valid && req_write && !req_is_data) begin
            if (req_index == `PMOF_STAT0_IDX) begin
                d.fr  = req_wdata[`PMOF_FR_BIT];
                d.ovf = req_wdata[`PMOF_MS_BIT:`PMOF_FIRST_CTR];
            end else if (in_ctr_range) begin
                d.cfg[sel].plm       = req_wdata[`PMOF_PLM_LSB +: 4];
                d.cfg[sel].oi        = req_wdata[`PMOF_OI_BIT];
                d.cfg[sel].pm        = req_wdata[`PMOF_PM_BIT];
                d.cfg[sel].es_cycles = req_wdata[`PMOF_ES_LSB];
            end
        end
        // hardware sets win over a same-cycle clear, and never clear
        d.ovf[`PMOF_LAST_CTR:`PMOF_FIRST_CTR] = d.ovf[`PMOF_LAST_CTR:`PMOF_FIRST_CTR]
                                                | ctr_ovf;
        d.ovf[`PMOF_MS_BIT] = d.ovf[`PMOF_MS_BIT] | ms_evt;
        if (irq_evt) begin
            d.fr = 1'b1;
        end
        d.irq = irq_evt & ~overflow_vector_mask;
        // reads answer one cycle later, no side effects
        if (req_valid && !req_write) begin
            d.rvalid = 1'b1;
            d.rdata  = 64'h0;
            if (req_is_data) begin
                if (in_ctr_range && ((current_priv_level == 2'h0) ||
                    (!q.cfg[sel].pm && !secure_monitor_flag))) begin
                    d.rdata = {{(64-W){ctr_cnt[sel][W-1]}}, ctr_cnt[sel]};
                end
            end else if (req_index == `PMOF_STAT0_IDX) begin
                d.rdata = stat0_view;
            end else if (in_ctr_range) begin
                d.rdata = {48'h0, 7'h0, q.cfg[sel].es_cycles, 1'b0, q.cfg[sel].pm,
                           q.cfg[sel].oi, 1'b0, q.cfg[sel].plm};
            end
            // status registers 1..3 hold no implemented counter: zero
        end
    end

    // state register; everything starts clear and unfrozen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q.fr     <= `PMOF_FR_RST;
            q.ovf    <= `PMOF_OVF_RST;
            q.cfg    <= '0;
            q.rdata  <= 64'h0;
            q.rvalid <= 1'b0;
            q.irq    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign rsp_rdata     = q.rdata;
    assign rsp_valid     = q.rvalid;
    assign freeze_bit    = q.fr;
    assign perf_irq_pend = q.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_read_gate;
        (req_valid && !req_write && req_is_data && in_ctr_range &&
         current_priv_level != 2'h0 && (q.cfg[sel].pm || secure_monitor_flag))
        |=> (rsp_valid && rsp_rdata == 64'h0);
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("gated read not zero");

    property p_mono;
        (ctr_inc[0] && !cif[0].wr && !ctr_ovf[0]) |=> (ctr_cnt[0] == $past(ctr_cnt[0]) + 1);
    endproperty
    a_mono: assert property (p_mono) else $error("counter did not step up");

    // slot 2 is the counter that the bench wraps with its interrupt bit set
    property p_ovf_freeze;
        (ctr_ovf[2] && ctr_oi[2]) |=> (q.fr && q.ovf[6]);
    endproperty
    a_ovf_freeze: assert property (p_ovf_freeze) else $error("overflow missed freeze");

    property p_no_freeze;
        (ctr_ovf[0] && !ctr_oi[0] && !irq_evt && !q.fr && !stat_wr0)
        |=> (!q.fr && q.ovf[4]);
    endproperty
    a_no_freeze: assert property (p_no_freeze) else $error("quiet overflow froze");

    property p_irq_mask;
        irq_evt |=> (perf_irq_pend == !$past(overflow_vector_mask));
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("pend ignores mask");

    property p_stat0_ign;
        (req_valid && !req_write && !req_is_data && req_index == `PMOF_STAT0_IDX)
        |=> (rsp_rdata[3:1] == 3'h0);
    endproperty
    a_stat0_ign: assert property (p_stat0_ign) else $error("bits 3:1 not zero");

    // every wrapping counter lands on its own status bit, several at once too
    property p_ovf_map;
        (|ctr_ovf) |=> ((q.ovf[`PMOF_LAST_CTR:`PMOF_FIRST_CTR] & $past(ctr_ovf)) == $past(ctr_ovf));
    endproperty
    a_ovf_map: assert property (p_ovf_map) else $error("overflow bit not set");

    property p_frozen_hold;
        (q.fr && !stat_wr0 && !data_wr) [*2] |-> ($stable(ctr_cnt[2]) && $stable(q.ovf));
    endproperty
    a_frozen_hold: assert property (p_frozen_hold) else $error("moved while frozen");

    property p_sticky;
        !stat_wr0 |=> (($past(q.ovf) & ~q.ovf) == '0) && ($past(q.fr) <= q.fr);
    endproperty
    a_sticky: assert property (p_sticky) else $error("hardware cleared a bit");

    property p_unimpl;
        (req_valid && !req_write && !req_is_data && req_index >= `PMOF_STAT1_IDX &&
         req_index <= `PMOF_STAT3_IDX) |=> (rsp_rdata == 64'h0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits nonzero");

    // slot 0 is the cycle-counting counter in normal use
    property p_cycle_evt;
        (!q.fr && q.cfg[0].es_cycles && q.cfg[0].plm[current_priv_level] &&
         (q.cfg[0].pm ? priv_monitor_enable : user_monitor_enable)) |-> ctr_inc[0];
    endproperty
    a_cycle_evt: assert property (p_cycle_evt) else $error("enabled counter idle");

    property p_no_after;
        (ctr_ovf[2] && ctr_oi[2]) |=> (ctr_inc == '0);
    endproperty
    a_no_after: assert property (p_no_after) else $error("counted after freeze");

    c_ovf_irq:    cover property (irq_evt && !overflow_vector_mask);
    c_multi_ovf:  cover property (ctr_ovf[0] && ctr_ovf[1]);
    c_gated_read: cover property (req_valid && !req_write && req_is_data && secure_monitor_flag);
    c_sw_freeze:  cover property (stat_wr0 && req_wdata[`PMOF_FR_BIT]);
endmodule : pmof_top
`default_nettype wire

/* File: tb/pmof_cpu_model.sv */
// processor-side requester issuing move-to and move-from monitor requests
`timescale 1ns/1ps
`default_nettype none
module pmof_cpu_model (
    // clock
    input  wire logic        mclk,
    // request side
    output logic             req_valid,
    output logic             req_write,
    output logic             req_is_data,
    output logic [7:0]       req_index,
    output logic [63:0]      req_wdata,
    // answer side
    input  wire logic [63:0] rsp_rdata,
    input  wire logic        rsp_valid
);
    // idle from time zero
    initial begin
        req_valid   = 1'b0;
        req_write   = 1'b0;
        req_is_data = 1'b0;
        req_index   = 8'h00;
        req_wdata   = 64'h0;
    end

    // one request per call; the next call starts a cycle later, so a write has landed
    // non-counter data is never read here, and no enable change follows a read unserialized
    task automatic xfer(input logic w, input logic d, input logic [7:0] idx,
                        input logic [63:0] wd, output logic [63:0] rd);
        @(posedge mclk);
        req_valid   <= 1'b1;
        req_write   <= w;
        req_is_data <= d;
        req_index   <= idx;
        req_wdata   <= wd;
        @(posedge mclk);
        req_valid   <= 1'b0;
        req_index   <= ~idx; // released index and data lines do not keep their last value
        req_wdata   <= ~wd;
        #1;
        rd = (rsp_valid === 1'b1) ? rsp_rdata : 64'hx;
    endtask : xfer
endmodule : pmof_cpu_model
`default_nettype wire

/* File: tb/pmof_tb_top.sv */
// self-checking bench for the overflow status and freeze block
`timescale 1ns/1ps
`default_nettype none
module pmof_tb_top;
    logic        mclk, rst_n, user_monitor_enable, priv_monitor_enable;
    logic        secure_monitor_flag, overflow_vector_mask, evt_retired_instr, ms_irq_req;
    logic [1:0]  current_priv_level;
    logic        req_valid, req_write, req_is_data, rsp_valid, freeze_bit, perf_irq_pend;
    logic [7:0]  req_index;
    logic [63:0] req_wdata, rsp_rdata, a, b;
    logic        seen;
    int          failures, checked;

    pmof_top i_pmof_top (.mclk, .rst_n, .current_priv_level, .user_monitor_enable,
        .priv_monitor_enable, .secure_monitor_flag, .overflow_vector_mask, .evt_retired_instr,
        .ms_irq_req, .req_valid, .req_write, .req_is_data, .req_index, .req_wdata,
        .rsp_rdata, .rsp_valid, .freeze_bit, .perf_irq_pend);
    pmof_cpu_model i_pmof_cpu_model (.mclk, .req_valid, .req_write, .req_is_data,
        .req_index, .req_wdata, .rsp_rdata, .rsp_valid);

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [63:0] cfg(logic [3:0] plm, logic oi, logic pm, logic es);
        return {55'h0, es, 1'b0, pm, oi, 1'b0, plm};
    endfunction : cfg

    task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic wr(input logic d, input logic [7:0] i, input logic [63:0] v);
        logic [63:0] t;
        i_pmof_cpu_model.xfer(1'b1, d, i, v, t);
    endtask : wr

    task automatic rc(input string n, input logic d, input logic [7:0] i, input logic [63:0] e);
        logic [63:0] t;
        i_pmof_cpu_model.xfer(1'b0, d, i, 64'h0, t);
        check(n, e, t);
    endtask : rc

    // pend is a one-cycle pulse, so every cycle of the window is looked at
    task automatic wait_pend;
        seen = 1'b0;
        repeat (20) begin
            @(posedge mclk);
            #1;
            if (perf_irq_pend === 1'b1) seen = 1'b1;
        end
    endtask : wait_pend

    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // hang guard, far beyond the roughly 175 cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        failures = 0;
        checked = 0;
        rst_n = 1'b0;
        current_priv_level = 2'h0;
        {user_monitor_enable, priv_monitor_enable} = 2'h3;
        {secure_monitor_flag, overflow_vector_mask, evt_retired_instr, ms_irq_req} = 4'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rc("status0 after reset", 1'b0, 8'h00, 64'h0);
        // counter 4 on cycles, no interrupt: wraps, sets bit 4 only
        wr(1'b0, 8'h04, cfg(4'h1, 1'b0, 1'b0, 1'b1));
        wr(1'b1, 8'h04, 64'hffff_fffd);
        repeat (8) @(posedge mclk);
        rc("status0 wrap", 1'b0, 8'h00, 64'h10);
        check("freeze after wrap", 64'h0, {63'h0, freeze_bit});
        i_pmof_cpu_model.xfer(1'b0, 1'b1, 8'h04, 64'h0, a);
        i_pmof_cpu_model.xfer(1'b0, 1'b1, 8'h04, 64'h0, b);
        check("count rises", 64'h1, {63'h0, b > a});
        // counter 7 on retired instructions: exactly three events
        wr(1'b0, 8'h07, cfg(4'h1, 1'b0, 1'b0, 1'b0));
        wr(1'b1, 8'h07, 64'h0);
        rc("instr idle", 1'b1, 8'h07, 64'h0);
        evt_retired_instr <= 1'b1;
        repeat (3) @(posedge mclk);
        evt_retired_instr <= 1'b0;
        rc("instr count", 1'b1, 8'h07, 64'h3);
        // read gating over level, privileged bit and secure flag
        wr(1'b1, 8'h05, 64'h8000_0001);
        for (int k = 0; k < 16; k++) begin
            current_priv_level <= k[1:0];
            secure_monitor_flag <= k[2];
            wr(1'b0, 8'h05, cfg(4'h0, 1'b0, k[3], 1'b0));
            rc("gated read", 1'b1, 8'h05,
               (k[1:0] != 0 && (k[3] || k[2])) ? 64'h0 : 64'hffff_ffff_8000_0001);
        end
        current_priv_level <= 2'h0;
        secure_monitor_flag <= 1'b0;
        // model-specific request sets its bit and freezes
        @(posedge mclk);
        ms_irq_req <= 1'b1;
        @(posedge mclk);
        ms_irq_req <= 1'b0;
        rc("status0 ms", 1'b0, 8'h00, 64'h111);
        i_pmof_cpu_model.xfer(1'b0, 1'b1, 8'h04, 64'h0, a);
        rc("frozen count", 1'b1, 8'h04, a);
        wr(1'b0, 8'h00, 64'h0);
        check("freeze cleared", 64'h0, {63'h0, freeze_bit});
        // software freeze; ignored and unimplemented bits read zero
        wr(1'b0, 8'h00, 64'h8000_0000_0000_000f);
        rc("status0 write", 1'b0, 8'h00, 64'h1);
        wr(1'b0, 8'h01, 64'hffff_ffff_ffff_ffff);
        rc("status1", 1'b0, 8'h01, 64'h0);
        wr(1'b0, 8'h04, cfg(4'h0, 1'b0, 1'b0, 1'b1));
        wr(1'b0, 8'h00, 64'h0);
        // interrupting overflow on counter 6, vector unmasked
        wr(1'b0, 8'h06, cfg(4'h1, 1'b1, 1'b0, 1'b1));
        wr(1'b1, 8'h06, 64'hffff_fffe);
        wait_pend();
        check("pend unmasked", 64'h1, {63'h0, seen});
        rc("status0 oi", 1'b0, 8'h00, 64'h41);
        rc("count after oi", 1'b1, 8'h06, 64'h0);
        // same overflow with the vector masked
        wr(1'b0, 8'h00, 64'h0);
        wr(1'b1, 8'h06, 64'hffff_fffe);
        overflow_vector_mask <= 1'b1;
        wait_pend();
        check("pend masked", 64'h0, {63'h0, seen});
        check("freeze masked", 64'h1, {63'h0, freeze_bit});
        give_verdict();
    end
endmodule : pmof_tb_top
`default_nettype wire
